// [src/fcm_master.sv]
// Master configuration port: serial and byte-wide flash loader with register slave.
//
// Summary of operation
// - Mode 001 selects serial flash master; config clock comes from own divider.
// - Variant select picks read command and dummy bytes; other codes are refused.
// - Supported reads are standard 0x03 and fast 0x0b.
// - Chain head forwards later data on chain data at config clock fall.
// - Program restart held low floats every configuration pin.
// - Pull-ups enabled while pull-up disable is low during configuration.
// - Mode pins sampled as init rises; user I/O after completion.
// - Byte-wide mode 01x: bit0 low counts up from 0, high down from 0xfffff.
// - Flash shared with processor: one boots, device reads the opposite end.
// - Write input is active-low write; readback only after completion with keep.
// - Chain select, config clock and busy stay driven during configuration.
// - PROM chip and output enables driven low throughout configuration.
// - After completion software can deselect the PROM; its pins turn user I/O.
// - After completion pins turn user I/O unless keep holds the parallel port.
// - Keep also reserves address lines 20 to 23.
// - Config complete held low while configuring, released on success.
// - Restart low at least 500 ns clears and restarts on release.
// - Init held low while clearing; external low makes the sequencer wait.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
module fcm_master (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        program_restart_n_in,
  input  wire logic        init_status_n_in,
  input  wire logic [2:0]  config_mode_in,
  input  wire logic [2:0]  spi_variant_select_in,
  input  wire logic        io_pullup_disable_in,
  input  wire logic        parallel_write_n_in,
  input  wire logic        parallel_chip_select_n_in,
  input  wire logic        flash_miso_in,
  input  wire logic [7:0]  flash_data_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             init_status_n_out,
  output logic             init_status_n_oe_n_out,
  output logic             config_complete_out,
  output logic             config_complete_oe_n_out,
  output logic             config_clock_out,
  output logic             flash_select_n_out,
  output logic             flash_mosi_out,
  output logic             chain_data_out,
  output logic             chain_select_out_n_out,
  output logic             busy_out,
  output logic [23:0]      flash_address_out,
  output logic             prom_chip_enable_n_out,
  output logic             prom_output_enable_n_out,
  output logic             config_pins_oe_n_out,
  output logic             pullup_enable_out,
  output logic             user_io_out,
  output logic             keep_config_port_out,
  output logic             upper_address_reserved_out,
  output logic             readback_enable_out
);

  typedef struct packed {
    fcm_pkg::fcm_pins_type pm;
    fcm_pkg::fcm_pins_type ps;
    fcm_pkg::fcm_state_type st;
    logic [2:0]  phase;
    logic        config_clock;
    logic        tick_rise;
    logic        tick_fall;
    logic [4:0]  lowcnt;
    logic [7:0]  clrcnt;
    logic [2:0]  mode;
    logic [2:0]  vs;
    logic [1:0]  dummy;
    logic [23:0] cnt;
    logic [23:0] addr;
    logic [7:0]  sum;
    logic        go;
    logic [7:0]  tx;
    logic        cs_n;
    logic        chain_d;
    logic        chain_sel_n;
    logic        chain_end;
    logic        clk_on;
    logic        low;
    logic        cfg_oe_n;
    logic        done_oe_n;
    logic        init_oe_n;
    logic        pull_en;
    logic        ce_n;
    logic        keep_port;
    logic        user_io;
    logic        readback;
    logic [1:0]  ctrl;
    logic [23:0] own_len;
    logic [23:0] chain_len;
    logic        wait_r;
    logic [31:0] rdata;
  } fcm_main_type;

  fcm_main_type r_reg;
  fcm_main_type r_next;
  fcm_shift_if  sh ();

  fcm_shifter u_shift (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .sh      (sh)
  );

  function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [23:0] v;
    v = old;
    if (be[0]) v[7:0] = wd[7:0];
    if (be[1]) v[15:8] = wd[15:8];
    if (be[2]) v[23:16] = wd[23:16];
    return v;
  endfunction

  function automatic logic is_spi(input fcm_pkg::fcm_state_type s);
    return s inside {fcm_pkg::ST_SPI_CMD, fcm_pkg::ST_SPI_ADDR, fcm_pkg::ST_SPI_DUMMY,
                     fcm_pkg::ST_SPI_LOAD, fcm_pkg::ST_CHAIN};
  endfunction

  always_comb begin
    logic run;
    logic fin;
    run = is_spi(r_reg.st) || (r_reg.st == fcm_pkg::ST_BPI_LOAD);
    fin = 1'b0;
    r_next = r_reg;
    r_next.pm = {program_restart_n_in, init_status_n_in, config_mode_in, spi_variant_select_in,
                 io_pullup_disable_in, flash_miso_in, flash_data_in, parallel_write_n_in,
                 parallel_chip_select_n_in};
    r_next.ps = r_reg.pm;
    r_next.go = 1'b0;
    r_next.low = 1'b0;
    // Config clock is the system clock divided down; ticks mark its edges.
    r_next.phase = (r_reg.phase == fcm_pkg::LINK_DIV_LAST) ? 3'h0 : r_reg.phase + 3'h1;
    // The serial clock waits for the first presented bit, so the flash never counts a bit that was not sent.
    r_next.clk_on = is_spi(r_reg.st) && (r_reg.clk_on || (r_reg.tick_fall && sh.busy));
    r_next.config_clock = run && r_next.phase[2] && (r_reg.clk_on || (r_reg.st == fcm_pkg::ST_BPI_LOAD));
    r_next.tick_rise = run && (r_next.phase == fcm_pkg::PH_RISE);
    r_next.tick_fall = run && (r_next.phase == fcm_pkg::PH_FALL);

    unique case (r_reg.st)
      fcm_pkg::ST_CLEAR: begin
        if (r_reg.ps.prog) begin
          r_next.clrcnt = r_reg.clrcnt + 8'h01;
          if (r_reg.clrcnt == fcm_pkg::CLEAR_CYC) r_next.st = fcm_pkg::ST_WAIT_INIT;
        end
      end
      fcm_pkg::ST_WAIT_INIT: begin
        // A party holding init low keeps the sequencer here.
        if (r_reg.ps.init) begin
          r_next.mode = r_reg.ps.mode;
          r_next.vs = r_reg.ps.vs;
          r_next.st = fcm_pkg::ST_SAMPLE;
        end
      end
      fcm_pkg::ST_SAMPLE: begin
        r_next.cnt = 24'h000000;
        r_next.chain_end = 1'b0;
        if (r_reg.mode == fcm_pkg::MODE_SPI) begin
          r_next.addr = fcm_pkg::SPI_START;
          if (r_reg.vs == fcm_pkg::VS_FAST) begin
            r_next.tx = fcm_pkg::CMD_FAST;
            r_next.dummy = fcm_pkg::DUMMY_FAST;
            r_next.st = fcm_pkg::ST_SPI_CMD;
          end else if (r_reg.vs == fcm_pkg::VS_READ) begin
            r_next.tx = fcm_pkg::CMD_READ;
            r_next.dummy = fcm_pkg::DUMMY_READ;
            r_next.st = fcm_pkg::ST_SPI_CMD;
          end else begin
            r_next.st = fcm_pkg::ST_FAULT;
          end
        end else if (r_reg.mode[2:1] == fcm_pkg::MODE_BPI_HI) begin
          // Starting end is strapped so a processor can boot from the other end.
          r_next.addr = r_reg.mode[0] ? fcm_pkg::BPI_TOP : 24'h000000;
          // Entering just after a rise gives the first address a whole link period to settle.
          if (r_reg.phase == fcm_pkg::PH_RISE) r_next.st = fcm_pkg::ST_BPI_LOAD;
        end else begin
          r_next.st = fcm_pkg::ST_FAULT;
        end
      end
      fcm_pkg::ST_SPI_CMD, fcm_pkg::ST_SPI_ADDR, fcm_pkg::ST_SPI_DUMMY,
      fcm_pkg::ST_SPI_LOAD, fcm_pkg::ST_CHAIN: begin
        if (sh.done) begin
          r_next.cnt = r_reg.cnt + 24'h000001;
          r_next.tx = 8'h00;
          unique case (r_reg.st)
            fcm_pkg::ST_SPI_CMD: begin
              r_next.cnt = 24'h000000;
              r_next.tx = r_reg.addr[23:16];
              r_next.st = fcm_pkg::ST_SPI_ADDR;
            end
            fcm_pkg::ST_SPI_ADDR: begin
              r_next.addr = {r_reg.addr[15:0], 8'h00};
              r_next.tx = r_reg.addr[15:8];
              if (r_reg.cnt == 24'h000002) begin
                r_next.cnt = 24'h000000;
                r_next.tx = 8'h00;
                r_next.st = (r_reg.dummy != 2'h0) ? fcm_pkg::ST_SPI_DUMMY : fcm_pkg::ST_SPI_LOAD;
              end
            end
            fcm_pkg::ST_SPI_DUMMY: begin
              if (r_reg.cnt == 24'({r_reg.dummy - 2'h1})) begin
                r_next.cnt = 24'h000000;
                r_next.st = fcm_pkg::ST_SPI_LOAD;
              end
            end
            fcm_pkg::ST_SPI_LOAD: begin
              r_next.sum = r_reg.sum + sh.rx_byte;
              if (r_reg.cnt == r_reg.own_len - 24'h000001) begin
                r_next.cnt = 24'h000000;
                if (r_reg.chain_len != 24'h000000) r_next.st = fcm_pkg::ST_CHAIN;
                else fin = 1'b1;
              end
            end
            default: begin
              // The last chain bit still has to reach the chain output and see one more clock rise.
              if (r_reg.cnt == r_reg.chain_len - 24'h000001) r_next.chain_end = 1'b1;
            end
          endcase
        end else if (!sh.busy && !r_reg.go && !r_reg.chain_end) begin
          r_next.go = 1'b1;
        end
        if (r_reg.chain_end && r_reg.tick_rise) fin = 1'b1;
      end
      fcm_pkg::ST_BPI_LOAD: begin
        if (r_reg.tick_rise) begin
          r_next.sum = r_reg.sum + r_reg.ps.data;
          r_next.addr = r_reg.mode[0] ? r_reg.addr - 24'h000001 : r_reg.addr + 24'h000001;
          r_next.cnt = r_reg.cnt + 24'h000001;
          if (r_reg.cnt == r_reg.own_len - 24'h000001) fin = 1'b1;
        end
      end
      fcm_pkg::ST_DONE, fcm_pkg::ST_FAULT: begin
      end
      default: r_next.st = fcm_pkg::ST_FAULT;
    endcase
    if (fin) r_next.st = fcm_pkg::ST_DONE;

    // Chain bits come from the flash stream and change with the clock fall.
    if ((r_reg.st == fcm_pkg::ST_CHAIN) && r_next.tick_fall) r_next.chain_d = sh.rx_bit;

    // A short restart pulse only floats the pins; a long one restarts on release.
    if (!r_reg.ps.prog) begin
      if (r_reg.lowcnt != fcm_pkg::RESTART_MIN_CYC) r_next.lowcnt = r_reg.lowcnt + 5'h01;
    end else begin
      r_next.lowcnt = 5'h00;
      if (r_reg.lowcnt == fcm_pkg::RESTART_MIN_CYC) begin
        r_next.st = fcm_pkg::ST_CLEAR;
        r_next.clrcnt = 8'h00;
        r_next.sum = 8'h00;
        r_next.cnt = 24'h000000;
        r_next.chain_end = 1'b0;
      end
    end

    r_next.cs_n = !is_spi(r_next.st);
    r_next.chain_sel_n = (r_next.st != fcm_pkg::ST_CHAIN);
    r_next.init_oe_n = (r_next.st != fcm_pkg::ST_CLEAR);
    r_next.done_oe_n = (r_next.st == fcm_pkg::ST_DONE);
    r_next.ce_n = (r_next.st == fcm_pkg::ST_DONE) && r_reg.ctrl[fcm_pkg::CTRL_DESEL];
    r_next.pull_en = (r_next.st != fcm_pkg::ST_DONE) && !r_reg.ps.io_pullup_disable;
    r_next.keep_port = (r_next.st == fcm_pkg::ST_DONE) && r_reg.ctrl[fcm_pkg::CTRL_KEEP];
    r_next.user_io = (r_next.st == fcm_pkg::ST_DONE) && !r_reg.ctrl[fcm_pkg::CTRL_KEEP];
    r_next.cfg_oe_n = r_next.user_io;
    r_next.readback = r_next.keep_port && !r_reg.ps.cs_n && r_reg.ps.wr_n;
    if (!r_reg.ps.prog) begin
      r_next.cfg_oe_n = 1'b1;
      r_next.done_oe_n = 1'b1;
      r_next.init_oe_n = 1'b1;
    end

    // Each request is held one cycle with waitrequest high, then answered.
    r_next.wait_r = 1'b1;
    if ((avs_read_in || avs_write_in) && r_reg.wait_r) begin
      r_next.wait_r = 1'b0;
      r_next.rdata = 32'h00000000;
      unique case (avs_address_in)
        fcm_pkg::REG_CTRL: r_next.rdata[1:0] = r_reg.ctrl;
        fcm_pkg::REG_OWN_LEN: r_next.rdata[23:0] = r_reg.own_len;
        fcm_pkg::REG_CHAIN_LEN: r_next.rdata[23:0] = r_reg.chain_len;
        fcm_pkg::REG_STATUS: begin
          r_next.rdata[fcm_pkg::STAT_STATE_LSB +: 4] = r_reg.st;
          r_next.rdata[fcm_pkg::STAT_MODE_LSB +: 3] = r_reg.mode;
          r_next.rdata[fcm_pkg::STAT_VS_LSB +: 3] = r_reg.vs;
          r_next.rdata[fcm_pkg::STAT_DONE_BIT] = (r_reg.st == fcm_pkg::ST_DONE);
          r_next.rdata[fcm_pkg::STAT_FAULT_BIT] = (r_reg.st == fcm_pkg::ST_FAULT);
        end
        fcm_pkg::REG_SUM: r_next.rdata[7:0] = r_reg.sum;
        default: r_next.rdata = 32'h00000000;
      endcase
    end
    if (avs_write_in && !r_reg.wait_r) begin
      unique case (avs_address_in)
        fcm_pkg::REG_CTRL: begin
          if (avs_byteenable_in[0]) r_next.ctrl = avs_writedata_in[1:0];
        end
        fcm_pkg::REG_OWN_LEN:
          r_next.own_len = merge24(r_reg.own_len, avs_writedata_in, avs_byteenable_in);
        fcm_pkg::REG_CHAIN_LEN:
          r_next.chain_len = merge24(r_reg.chain_len, avs_writedata_in, avs_byteenable_in);
        default: r_next.wait_r = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_reg <= '0;
      r_reg.st <= fcm_pkg::ST_CLEAR;
      r_reg.cs_n <= 1'b1;
      r_reg.chain_sel_n <= 1'b1;
      r_reg.ctrl <= fcm_pkg::CTRL_RST;
      r_reg.own_len <= fcm_pkg::OWN_LEN_RST;
      r_reg.chain_len <= fcm_pkg::CHAIN_LEN_RST;
      r_reg.wait_r <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sh.tick_rise = r_reg.tick_rise;
  assign sh.tick_fall = r_reg.tick_fall;
  assign sh.go        = r_reg.go;
  assign sh.tx_byte   = r_reg.tx;
  assign sh.miso      = r_reg.ps.miso;

  assign avs_readdata_out           = r_reg.rdata;
  assign avs_waitrequest_out        = r_reg.wait_r;
  assign init_status_n_out          = r_reg.low;
  assign init_status_n_oe_n_out     = r_reg.init_oe_n;
  assign config_complete_out        = r_reg.low;
  assign config_complete_oe_n_out   = r_reg.done_oe_n;
  assign config_clock_out           = r_reg.config_clock;
  assign flash_select_n_out         = r_reg.cs_n;
  assign flash_mosi_out             = sh.mosi;
  assign chain_data_out             = r_reg.chain_d;
  assign chain_select_out_n_out     = r_reg.chain_sel_n;
  assign busy_out                   = r_reg.low;
  assign flash_address_out          = r_reg.addr;
  assign prom_chip_enable_n_out     = r_reg.ce_n;
  assign prom_output_enable_n_out   = r_reg.low;
  assign config_pins_oe_n_out       = r_reg.cfg_oe_n;
  assign pullup_enable_out          = r_reg.pull_en;
  assign user_io_out                = r_reg.user_io;
  assign keep_config_port_out       = r_reg.keep_port;
  assign upper_address_reserved_out = r_reg.keep_port;
  assign readback_enable_out        = r_reg.readback;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence long_low_s;
    !r_reg.ps.prog && (r_reg.lowcnt == fcm_pkg::RESTART_MIN_CYC);
  endsequence
  sequence release_s;
    long_low_s ##1 r_reg.ps.prog;
  endsequence

  restart_after_long_a: assert property (release_s |=> r_reg.st == fcm_pkg::ST_CLEAR)
    else $error("long restart pulse did not restart configuration");
  float_on_restart_a: assert property (!r_reg.ps.prog |=> r_reg.cfg_oe_n && r_reg.done_oe_n && r_reg.init_oe_n)
    else $error("pins driven while restart held low");
  done_low_cfg_a: assert property (r_reg.ps.prog && $past(r_reg.ps.prog) && (r_reg.st != fcm_pkg::ST_DONE) |->
      !r_reg.done_oe_n)
    else $error("config complete released before completion");
  init_wait_a: assert property (r_reg.st == fcm_pkg::ST_WAIT_INIT && !r_reg.ps.init |=> r_reg.st == fcm_pkg::ST_WAIT_INIT)
    else $error("sequencer left wait with init low");
  spi_select_a: assert property (is_spi(r_reg.st) |-> !r_reg.cs_n)
    else $error("flash select high during serial read");
  cmd_pick_a: assert property ($rose(r_reg.go) && r_reg.st == fcm_pkg::ST_SPI_CMD |->
      r_reg.tx == ((r_reg.vs == fcm_pkg::VS_FAST) ? fcm_pkg::CMD_FAST : fcm_pkg::CMD_READ))
    else $error("wrong read command for variant");
  bpi_start_a: assert property (r_reg.st == fcm_pkg::ST_SAMPLE && r_reg.mode == 3'h3 && r_reg.ps.prog |=>
      r_reg.addr == fcm_pkg::BPI_TOP)
    else $error("descending load did not start at top");
  prom_enable_a: assert property (r_reg.st == fcm_pkg::ST_BPI_LOAD |-> !r_reg.ce_n && !r_reg.low)
    else $error("prom enables not low during load");
  chain_fall_a: assert property ($changed(r_reg.chain_d) |-> $fell(r_reg.config_clock))
    else $error("chain data changed off the falling edge");
  pullup_cfg_a: assert property (r_reg.st inside {fcm_pkg::ST_SAMPLE, fcm_pkg::ST_BPI_LOAD} ##1
      r_reg.st != fcm_pkg::ST_DONE |-> r_reg.pull_en == !$past(r_reg.ps.io_pullup_disable))
    else $error("pull-up enable disagrees with pull-up disable");

endmodule

// [src/fcm_pkg.sv]
// Shared constants and types of the flash configuration master port.
package fcm_pkg;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int RESTART_MIN_NS = 500;
  localparam int LINK_PERIOD_NS = 160;
  localparam logic [4:0] RESTART_MIN_CYC =
    5'((RESTART_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] LINK_DIV_LAST =
    3'((LINK_PERIOD_NS / CLK_PERIOD_NS) - 1);
  localparam logic [7:0] CLEAR_CYC = 8'h3f;
  localparam logic [2:0] PH_RISE   = 3'h4;
  localparam logic [2:0] PH_FALL   = 3'h0;

  localparam logic [2:0] MODE_SPI   = 3'h1;
  localparam logic [1:0] MODE_BPI_HI = 2'h1;
  localparam logic [2:0] VS_FAST    = 3'h7;
  localparam logic [2:0] VS_READ    = 3'h5;
  localparam logic [7:0] CMD_READ   = 8'h03;
  localparam logic [7:0] CMD_FAST   = 8'h0b;
  localparam logic [1:0] DUMMY_FAST = 2'h1;
  localparam logic [1:0] DUMMY_READ = 2'h0;
  localparam logic [23:0] BPI_TOP   = 24'h0fffff;
  localparam logic [23:0] SPI_START = 24'h000000;

  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_OWN_LEN   = 8'h04;
  localparam logic [7:0] REG_CHAIN_LEN = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0c;
  localparam logic [7:0] REG_SUM       = 8'h10;

  localparam int CTRL_KEEP  = 0;
  localparam int CTRL_DESEL = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h0;
  localparam logic [23:0] OWN_LEN_RST   = 24'h000100;
  localparam logic [23:0] CHAIN_LEN_RST = 24'h000000;

  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MODE_LSB  = 4;
  localparam int STAT_VS_LSB    = 8;
  localparam int STAT_DONE_BIT  = 12;
  localparam int STAT_FAULT_BIT = 13;

  typedef enum logic [3:0] {
    ST_CLEAR, ST_WAIT_INIT, ST_SAMPLE, ST_SPI_CMD, ST_SPI_ADDR,
    ST_SPI_DUMMY, ST_SPI_LOAD, ST_CHAIN, ST_BPI_LOAD, ST_DONE, ST_FAULT
  } fcm_state_type;

  typedef struct packed {
    logic       prog;
    logic       init;
    logic [2:0] mode;
    logic [2:0] vs;
    logic       io_pullup_disable;
    logic       miso;
    logic [7:0] data;
    logic       wr_n;
    logic       cs_n;
  } fcm_pins_type;

endpackage

// [src/fcm_shift_if.sv]
// Carrier between the sequencer and the serial byte shifter.
interface fcm_shift_if;
  logic       tick_rise;
  logic       tick_fall;
  logic       go;
  logic [7:0] tx_byte;
  logic       miso;
  logic       busy;
  logic       done;
  logic [7:0] rx_byte;
  logic       rx_bit;
  logic       mosi;
  modport main  (output tick_rise, tick_fall, go, tx_byte, miso,
                 input busy, done, rx_byte, rx_bit, mosi);
  modport shift (input tick_rise, tick_fall, go, tx_byte, miso,
                 output busy, done, rx_byte, rx_bit, mosi);
endinterface

// [src/fcm_shifter.sv]
// Serial flash byte shifter driven by config clock edge ticks.
module fcm_shifter (
  input  wire logic  clk_in,
  input  wire logic  nrst_in,
  fcm_shift_if.shift sh
);

  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] cnt;
    logic       act;
    logic       pres;
    logic       done;
    logic       mosi;
    logic       bit_s;
  } fcm_shift_type;

  fcm_shift_type r_reg;
  fcm_shift_type r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (!r_reg.act) begin
      if (sh.go) begin
        r_next.act = 1'b1;
        r_next.tx = sh.tx_byte;
        r_next.cnt = 3'h0;
        r_next.pres = 1'b0;
      end
    end else begin
      // Bits leave on the falling edge so they are stable at the flash's rising-edge sample.
      if (sh.tick_fall && !r_reg.pres) begin
        r_next.mosi = r_reg.tx[7];
        r_next.tx = {r_reg.tx[6:0], 1'b0};
        r_next.pres = 1'b1;
      end
      if (sh.tick_rise && r_reg.pres) begin
        r_next.rx = {r_reg.rx[6:0], sh.miso};
        r_next.bit_s = sh.miso;
        r_next.pres = 1'b0;
        r_next.cnt = r_reg.cnt + 3'h1;
        if (r_reg.cnt == 3'h7) begin
          r_next.act = 1'b0;
          r_next.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sh.busy    = r_reg.act;
  assign sh.done    = r_reg.done;
  assign sh.rx_byte = r_reg.rx;
  assign sh.rx_bit  = r_reg.bit_s;
  assign sh.mosi    = r_reg.mosi;

endmodule

// [verif/fcm_flash_model.sv]
// Behavioural serial and byte-wide configuration flash.
module fcm_flash_model (
  input  wire logic        clk_in,
  input  wire logic        config_clock_in,
  input  wire logic        flash_select_n_in,
  input  wire logic        flash_mosi_in,
  input  wire logic        prom_chip_enable_n_in,
  input  wire logic [23:0] flash_address_in,
  output logic             flash_miso_out,
  output logic [7:0]       flash_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned nbit = 0;
  int unsigned hdr;
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  val;
  initial flash_miso_out = 1'b0;
  // A deselected flash floats, so the line toggles rather than hold a value.
  always @(posedge clk_in) if (flash_select_n_in) begin
    flash_miso_out <= ~flash_miso_out;
    nbit = 0;
  end
  always @(posedge config_clock_in) if (!flash_select_n_in) begin
    if (nbit < 8) cmd = {cmd[6:0], flash_mosi_in};
    nbit++;
  end
  // Data byte k after the header holds the value k, starting at 1.
  always @(negedge config_clock_in) if (!flash_select_n_in) begin
    hdr = (cmd == 8'h0b) ? 40 : 32;
    val = 8'((nbit - hdr) / 8 + 1);
    if (nbit >= hdr) flash_miso_out <= val[7 - (nbit - hdr) % 8];
  end
  // A deselected parallel flash gives the inverse of the address low byte.
  assign flash_data_out = prom_chip_enable_n_in ? ~flash_address_in[7:0] : flash_address_in[7:0];
endmodule

// [verif/testbench.sv]
// Self-checking bench of the flash configuration master port.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [2:0] m, v; logic h, f; logic [7:0] s;} fcm_row_type;
  fcm_row_type rows[6] = '{'{3'h1, 3'h2, 1'b0, 1'b1, 8'h00}, '{3'h4, 3'h0, 1'b1, 1'b1, 8'h00},
    '{3'h1, 3'h7, 1'b0, 1'b0, 8'h0a}, '{3'h1, 3'h5, 1'b1, 1'b0, 8'h0a},
    '{3'h2, 3'h0, 1'b0, 1'b0, 8'h06}, '{3'h3, 3'h0, 1'b1, 1'b0, 8'hf6}};
  logic clk_in = 1'b0, nrst_in = 1'b0, prog_n = 1'b1, ext_low = 1'b0, io_pullup_disable = 1'b0, wr_n = 1'b0;
  logic rd = 1'b0, wr = 1'b0, miso, init_oe_n, cc_oe_n, config_clock, sel_n, mosi, ch_d, ch_sel_n;
  logic ce_n, pins_oe_n, pu, wait_r, user_io, keep, upper, rb_en;
  logic [2:0] mode = 3'h0, vs = 3'h0;
  logic [7:0] addr = 8'h00, fdata, chain_sh = 8'h00;
  logic [23:0] faddr;
  logic [31:0] wdata = 32'h0, rdata, st;
  int failures = 0, compares = 0;
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
  initial forever #10 clk_in = ~clk_in;
  always @(posedge config_clock) if (!ch_sel_n) chain_sh <= {chain_sh[6:0], ch_d};
  fcm_master u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .program_restart_n_in(prog_n),
    .init_status_n_in(init_oe_n & !ext_low), .config_mode_in(mode), .spi_variant_select_in(vs),
    .io_pullup_disable_in(io_pullup_disable), .parallel_write_n_in(wr_n), .parallel_chip_select_n_in(1'b0),
    .flash_miso_in(miso), .flash_data_in(fdata), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_r), .init_status_n_out(), .init_status_n_oe_n_out(init_oe_n),
    .config_complete_out(), .config_complete_oe_n_out(cc_oe_n), .config_clock_out(config_clock),
    .flash_select_n_out(sel_n), .flash_mosi_out(mosi), .chain_data_out(ch_d),
    .chain_select_out_n_out(ch_sel_n), .busy_out(), .flash_address_out(faddr),
    .prom_chip_enable_n_out(ce_n), .prom_output_enable_n_out(), .config_pins_oe_n_out(pins_oe_n),
    .pullup_enable_out(pu), .user_io_out(user_io), .keep_config_port_out(keep),
    .upper_address_reserved_out(upper), .readback_enable_out(rb_en));
  fcm_flash_model u_flash (.clk_in(clk_in), .config_clock_in(config_clock), .flash_select_n_in(sel_n),
    .flash_mosi_in(mosi), .prom_chip_enable_n_in(ce_n), .flash_address_in(faddr),
    .flash_miso_out(miso), .flash_data_out(fdata));
  task automatic wrap_up();
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin @(posedge clk_in); n++; end while (wait_r !== 1'b0 && n < 100);
    st = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 100) begin failures++; wrap_up(); end
  endtask
  task automatic restart(input int n);
    @(posedge clk_in) prog_n <= 1'b0;
    repeat (n) @(posedge clk_in);
    `CHK(pins_oe_n, 1'b1)
    prog_n <= 1'b1;
  endtask
  task automatic wait_end();
    for (int n = 0; n <= 3000; n++) begin
      if (n == 3000) begin failures++; wrap_up(); end
      bus(1'b0, fcm_pkg::REG_STATUS, 32'h0);
      if (st[12] === 1'b1 || st[13] === 1'b1) break;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    bus(1'b0, 8'h40, 32'h0);
    `CHK(st, 32'h0)
    bus(1'b1, fcm_pkg::REG_OWN_LEN, 32'h4);
    bus(1'b1, fcm_pkg::REG_CHAIN_LEN, 32'h1);
    foreach (rows[i]) begin
      mode <= rows[i].m;
      vs <= rows[i].v;
      io_pullup_disable <= rows[i].h;
      restart(30);
      repeat (8) @(posedge clk_in);
      `CHK(pu, !rows[i].h)
      `CHK(cc_oe_n, 1'b0)
      `CHK(ce_n, 1'b0)
      wait_end();
      `CHK(st[13], rows[i].f)
      `CHK(st[6:4], rows[i].m)
      if (!rows[i].f) begin
        `CHK(cc_oe_n, 1'b1)
        bus(1'b0, fcm_pkg::REG_SUM, 32'h0);
        `CHK(st[7:0], rows[i].s)
        if (rows[i].m == 3'h1) `CHK(chain_sh, 8'h05)
      end
    end
    // A pulse shorter than the restart minimum must leave the device configured.
    restart(10);
    repeat (200) @(posedge clk_in);
    bus(1'b0, fcm_pkg::REG_STATUS, 32'h0);
    `CHK(st[12], 1'b1)
    bus(1'b1, fcm_pkg::REG_CTRL, 32'h1);
    wr_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    `CHK({keep, upper, user_io}, 3'b110)
    `CHK(rb_en, 1'b1)
    bus(1'b1, fcm_pkg::REG_CTRL, 32'h2);
    repeat (4) @(posedge clk_in);
    `CHK({ce_n, user_io}, 2'b11)
    wr_n <= 1'b0;
    ext_low <= 1'b1;
    restart(30);
    repeat (200) @(posedge clk_in);
    bus(1'b0, fcm_pkg::REG_STATUS, 32'h0);
    `CHK(st[3:0], 4'h1)
    ext_low <= 1'b0;
    wait_end();
    `CHK(st[12], 1'b1)
    wrap_up();
  end
endmodule
